// file: spi_sampler_if.sv
`timescale 1ns/1ps
// Summary of operation
// - Flow quantity reached: 500 ms output pulse
// - Wake line floats, grounds on set-point
// - Each accepted confirmation logs a timestamp
// - Bottle number stored with sample time
module spi_sampler_if
  import spi_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC,
  parameter int unsigned FLOW_MS = FLOW_PULSE_MS,
  parameter int unsigned EVENT_MS = EVENT_MIN_MS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Flow logic side
  input wire logic flowQuantityReached,
  input wire logic setPointMet,
  input wire logic [STAMP_W-1:0] timeStamp,
  // Sampler pins
  output logic flowPulseOut,
  output logic wakeOut,
  output logic wakeOe,
  input wire logic eventIn,
  input wire logic bottleIn,
  // Log output
  output logic logValid,
  output spi_entry_t logEntry
);

  typedef enum logic [1:0] {BT_IDLE, BT_HIGH, BT_LOW} spi_bstate_t;

  logic [31:0] divCnt_r, divCnt_nxt;
  logic tick_r, tick_nxt;
  logic [2:0] evSync_r, evSync_nxt;
  logic [2:0] btSync_r, btSync_nxt;
  logic evLvl_r, evLvl_nxt;
  logic btLvl_r, btLvl_nxt;
  logic [MS_W-1:0] flowCnt_r, flowCnt_nxt;
  logic flowPulse_r, flowPulse_nxt;
  logic wake_r, wake_nxt;
  logic [MS_W-1:0] evCnt_r, evCnt_nxt;
  logic evDone_r, evDone_nxt;
  spi_bstate_t bState_r, bState_nxt;
  logic [MS_W-1:0] bCnt_r, bCnt_nxt;
  logic [BOTTLE_W-1:0] pulses_r, pulses_nxt;
  logic firstHi_r, firstHi_nxt;
  logic fail_r, fail_nxt;
  logic [BOTTLE_W-1:0] lastBottle_r, lastBottle_nxt;
  logic lastFail_r, lastFail_nxt;
  logic logValid_r, logValid_nxt;
  spi_entry_t entry_r, entry_nxt;

  // Millisecond tick and pin synchronisers
  always_comb begin
    tick_nxt = 1'b0;
    divCnt_nxt = divCnt_r + 32'h1;
    if (divCnt_r >= TICK_CYCLES - 1) begin
      divCnt_nxt = 32'h0;
      tick_nxt = 1'b1;
    end
    evSync_nxt = {evSync_r[1:0], eventIn};
    btSync_nxt = {btSync_r[1:0], bottleIn};
    // Level changes only when stages two and three agree
    evLvl_nxt = (evSync_r[2] == evSync_r[1]) ? evSync_r[2] : evLvl_r;
    btLvl_nxt = (btSync_r[2] == btSync_r[1]) ? btSync_r[2] : btLvl_r;
  end

  // Flow pulse and wake line
  always_comb begin
    flowCnt_nxt = flowCnt_r;
    flowPulse_nxt = flowPulse_r;
    // A request during an active pulse is absorbed, not queued
    if (!flowPulse_r && flowQuantityReached) begin
      flowPulse_nxt = 1'b1;
      flowCnt_nxt = '0;
    end else if (flowPulse_r && tick_r) begin
      flowCnt_nxt = flowCnt_r + 1'b1;
      if (flowCnt_r >= MS_W'(FLOW_MS - 1)) begin
        flowPulse_nxt = 1'b0;
      end
    end
    wake_nxt = setPointMet;
  end

  // Bottle train decoder
  always_comb begin
    bState_nxt = bState_r;
    bCnt_nxt = bCnt_r;
    pulses_nxt = pulses_r;
    firstHi_nxt = firstHi_r;
    fail_nxt = fail_r;
    lastBottle_nxt = lastBottle_r;
    lastFail_nxt = lastFail_r;
    if (tick_r && bCnt_r != '1) begin
      bCnt_nxt = bCnt_r + 1'b1;
    end
    unique case (bState_r)
      BT_IDLE: begin
        if (btLvl_r) begin
          bState_nxt = BT_HIGH;
          bCnt_nxt = '0;
          pulses_nxt = '0;
          firstHi_nxt = 1'b1;
          fail_nxt = 1'b0;
        end
      end
      BT_HIGH: begin
        if (!btLvl_r) begin
          pulses_nxt = pulses_r + 1'b1;
          if (firstHi_r && bCnt_r >= MS_W'(FAIL_THR_MS)) begin
            fail_nxt = 1'b1;
          end
          firstHi_nxt = 1'b0;
          bState_nxt = BT_LOW;
          bCnt_nxt = '0;
        end
      end
      BT_LOW: begin
        if (btLvl_r) begin
          bState_nxt = BT_HIGH;
          bCnt_nxt = '0;
        end else if (bCnt_r >= MS_W'(END_GAP_MS)) begin
          // Only the first bottle of a set is ever sent; keep it
          lastBottle_nxt = pulses_r;
          lastFail_nxt = fail_r;
          bState_nxt = BT_IDLE;
        end
      end
    endcase
  end

  // Confirmation filter and log
  always_comb begin
    evCnt_nxt = evCnt_r;
    evDone_nxt = evDone_r;
    logValid_nxt = 1'b0;
    entry_nxt = entry_r;
    if (!evLvl_r) begin
      evCnt_nxt = '0;
      evDone_nxt = 1'b0;
    end else if (tick_r && !evDone_r) begin
      evCnt_nxt = evCnt_r + 1'b1;
      // Logged once per pulse, on reaching the minimum width
      if (evCnt_r >= MS_W'(EVENT_MS - 1)) begin
        evDone_nxt = 1'b1;
        logValid_nxt = 1'b1;
        entry_nxt.stamp = timeStamp;
        entry_nxt.bottle = lastBottle_r;
        entry_nxt.failed = lastFail_r;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      divCnt_r <= 32'h0;
      tick_r <= 1'b0;
      evSync_r <= 3'h0;
      btSync_r <= 3'h0;
      evLvl_r <= 1'b0;
      btLvl_r <= 1'b0;
      flowCnt_r <= '0;
      flowPulse_r <= 1'b0;
      wake_r <= 1'b0;
      evCnt_r <= '0;
      evDone_r <= 1'b0;
      bState_r <= BT_IDLE;
      bCnt_r <= '0;
      pulses_r <= '0;
      firstHi_r <= 1'b0;
      fail_r <= 1'b0;
      lastBottle_r <= '0;
      lastFail_r <= 1'b0;
      logValid_r <= 1'b0;
      entry_r <= '0;
    end else begin
      divCnt_r <= divCnt_nxt;
      tick_r <= tick_nxt;
      evSync_r <= evSync_nxt;
      btSync_r <= btSync_nxt;
      evLvl_r <= evLvl_nxt;
      btLvl_r <= btLvl_nxt;
      flowCnt_r <= flowCnt_nxt;
      flowPulse_r <= flowPulse_nxt;
      wake_r <= wake_nxt;
      evCnt_r <= evCnt_nxt;
      evDone_r <= evDone_nxt;
      bState_r <= bState_nxt;
      bCnt_r <= bCnt_nxt;
      pulses_r <= pulses_nxt;
      firstHi_r <= firstHi_nxt;
      fail_r <= fail_nxt;
      lastBottle_r <= lastBottle_nxt;
      lastFail_r <= lastFail_nxt;
      logValid_r <= logValid_nxt;
      entry_r <= entry_nxt;
    end
  end

  assign flowPulseOut = flowPulse_r;
  // Open drain: drive low only, float otherwise
  assign wakeOut = 1'b0;
  assign wakeOe = wake_r;
  assign logValid = logValid_r;
  assign logEntry = entry_r;

endmodule // spi_sampler_if

// file: spi_pkg.sv
package spi_pkg;

  localparam int unsigned CLK_HZ = 250_000_000;
  // Timing figures as specified, in milliseconds
  localparam int unsigned FLOW_PULSE_MS = 500;
  localparam int unsigned EVENT_MIN_MS = 3000;
  localparam int unsigned BIT_HALF_MS = 50;
  localparam int unsigned FAIL_HIGH_MS = 150;
  localparam int unsigned GAP_A_MS = 200;
  // One-millisecond tick divider
  localparam int unsigned TICK_CYC = CLK_HZ / 1000;
  // Thresholds in ms ticks: fail if first high above midpoint of 50 and 150
  localparam int unsigned FAIL_THR_MS = (BIT_HALF_MS + FAIL_HIGH_MS) / 2;
  // Train ends after a low longer than one low half plus margin
  localparam int unsigned END_GAP_MS = (GAP_A_MS + BIT_HALF_MS) / 2;
  localparam int unsigned MS_W = 16;
  localparam int unsigned BOTTLE_W = 8;
  localparam int unsigned STAMP_W = 32;

  typedef struct packed {
    logic [STAMP_W-1:0] stamp;
    logic [BOTTLE_W-1:0] bottle;
    logic failed;
  } spi_entry_t;

endpackage

// file: spi_sampler_if_asserts.sv
`timescale 1ns/1ps
module spi_sampler_if_asserts
  import spi_pkg::*;
#(parameter int unsigned TICK_CYCLES = TICK_CYC,
  parameter int unsigned FLOW_MS = FLOW_PULSE_MS,
  parameter int unsigned EVENT_MS = EVENT_MIN_MS) (
  // Clock, reset and inputs
  input logic clk,
  input logic rst_b,
  input logic flowQuantityReached,
  input logic setPointMet,
  input logic [STAMP_W-1:0] timeStamp,
  input logic eventIn,
  input logic bottleIn,
  // Outputs
  input logic flowPulseOut,
  input logic wakeOut,
  input logic wakeOe,
  input logic logValid,
  input spi_entry_t logEntry
);
  int unsigned hiCnt_r, runLen_r;
  always_ff @(posedge clk) begin
    hiCnt_r <= flowPulseOut ? hiCnt_r + 1 : 0;
    runLen_r <= eventIn ? runLen_r + 1 : 0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_flow_start: assert property (
    flowQuantityReached && !flowPulseOut |=> flowPulseOut)
    else $error("flow pulse did not start");
  a_flow_width: assert property (
    $fell(flowPulseOut) |-> hiCnt_r > (FLOW_MS - 1) * TICK_CYCLES
    && hiCnt_r <= (FLOW_MS + 1) * TICK_CYCLES)
    else $error("flow pulse width wrong");
  a_wake_pull: assert property (setPointMet |=> wakeOe)
    else $error("wake line not grounded");
  a_wake_float: assert property (!setPointMet |=> !wakeOe)
    else $error("wake line not released");
  a_wake_low: assert property (wakeOe |-> !wakeOut)
    else $error("wake drives high");
  // Synchroniser lags the raw pin, so look a few cycles back
  a_log_width: assert property (
    logValid |-> $past(runLen_r, 5) > (EVENT_MS - 3) * TICK_CYCLES)
    else $error("log from short pulse");
  a_log_single: assert property (logValid |=> !logValid [*8])
    else $error("double log");
  a_entry_hold: assert property (!logValid |-> $stable(logEntry))
    else $error("entry changed without log");
  cover property (logValid && logEntry.failed);
  cover property ($fell(flowPulseOut));
  cover property ($rose(wakeOe));
endmodule // spi_sampler_if_asserts

bind spi_sampler_if spi_sampler_if_asserts #(.TICK_CYCLES(TICK_CYCLES),
  .FLOW_MS(FLOW_MS), .EVENT_MS(EVENT_MS)) chk_i (.*);

// file: spi_sampler_model.sv
`timescale 1ns/1ps
module spi_sampler_model
  import spi_pkg::*;
#(parameter int TK = 2) (
  // Clock
  input logic clk,
  // Lines to the device
  output logic eventIn,
  output logic bottleIn
);
  initial begin
    eventIn = 0;
    bottleIn = 0;
  end
  task automatic seg(logic b, logic e, int ms);
    bottleIn = b;
    eventIn = e;
    repeat (ms * TK) @(posedge clk);
    #1;
  endtask
  // Program-complete output is off, so each sample sends a bottle
  task automatic sample(int n, bit fail, int evMs);
    seg(0, 0, GAP_A_MS);
    for (int i = 0; i < n; i++) begin
      seg(1, 0, (fail && i == 0) ? FAIL_HIGH_MS : BIT_HALF_MS);
      seg(0, 0, BIT_HALF_MS);
    end
    // Only one number per sample, even for multi-bottle sets
    seg(0, 1, evMs);
    seg(0, 0, GAP_A_MS);
  endtask
endmodule // spi_sampler_model

// file: spi_sampler_if_test.sv
`timescale 1ns/1ps
module spi_sampler_if_test
  import spi_pkg::*;
;
  localparam int TK = 2;
  localparam int FL = 8;
  localparam int EV = 200;
  logic clk = 0, rst_b = 0, flowQuantityReached = 0, setPointMet = 0;
  logic [STAMP_W-1:0] timeStamp = '0;
  logic flowPulseOut, wakeOut, wakeOe, eventIn, bottleIn, logValid;
  spi_entry_t logEntry, e, x;
  spi_entry_t expQ[$];
  int n_fail = 0, cmp_count = 0, hi;
  spi_sampler_if #(.TICK_CYCLES(TK), .FLOW_MS(FL), .EVENT_MS(EV))
    spi_sampler_if_i (.*);
  spi_sampler_model #(.TK(TK)) spi_sampler_model_i (.*);
  initial forever #2 clk = ~clk;
  always @(posedge clk) #1 timeStamp = timeStamp + 1;
  task automatic chk(bit ok, string m);
    cmp_count++;
    if (!ok) begin
      n_fail++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask
  task automatic wrap_up();
    $display("fails=%0d compares=%0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) if (logValid === 1'b1) begin
    chk(expQ.size() > 0, "unexpected log");
    if (expQ.size() > 0) begin
      e = expQ.pop_front();
      chk(logEntry.bottle === e.bottle, "bottle");
      chk(logEntry.failed === e.failed, "failed");
      chk(logEntry.stamp <= timeStamp && logEntry.stamp + 4 > timeStamp,
        "stamp");
    end
  end
  initial begin
    #240000;
    chk(0, "timeout");
    wrap_up();
  end
  initial begin : main
    int v;
    void'($urandom(32'h723F));
    repeat (2) @(posedge clk);
    #1 rst_b = 1;
    flowQuantityReached = 1;
    @(posedge clk);
    #1;
    hi = 0;
    // A repeat request inside the pulse must not stretch it
    while (flowPulseOut === 1'b1 && hi < 100) begin
      flowQuantityReached = (hi == 5);
      hi++;
      @(posedge clk);
      #1;
    end
    chk(hi > (FL - 1) * TK && hi <= (FL + 1) * TK, "flow");
    repeat (20) begin
      v = $urandom_range(1);
      setPointMet = v;
      @(posedge clk);
      #1 chk(wakeOe === v[0] && wakeOut === 1'b0, "wake");
    end
    // Pass 3 is a short confirmation that must not log
    for (int i = 0; i < 6; i++) begin
      x.bottle = (i == 3) ? 0 : $urandom_range(1, 6);
      x.failed = (i == 1);
      if (i != 3) expQ.push_back(x);
      spi_sampler_model_i.sample(x.bottle, x.failed,
        (i == 3) ? EV / 2 : EV + 20);
    end
    chk(expQ.size() == 0, "missing log");
    wrap_up();
  end
endmodule // spi_sampler_if_test
